// [epc_panel.sv]
`timescale 1ns/1ps
`include "epc_defines.svh"
module epc_panel #(
  parameter logic [19:0] P_DB_CYCLES   = 20'(`EPC_DEBOUNCE_CYCLES),
  parameter logic [23:0] P_HALF_CYCLES = 24'(`EPC_HALF_SEC_CYCLES)
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_btn_right,
  input  wire logic        i_btn_up,
  input  wire logic        i_btn_down,
  input  wire logic        i_btn_enter,
  input  wire logic        i_ext_switch,
  input  wire logic [1:0]  i_sw_func,
  input  wire logic        i_sw_positive,
  input  wire logic [15:0] i_override_max_s,
  input  wire logic        i_purging,
  input  wire logic        i_purge_done,
  input  wire logic        i_pressure_low,
  input  wire logic        i_pressure_high,
  output logic      [5:0]  o_mode,
  output logic             o_lamp_red,
  output logic             o_lamp_green,
  output logic             o_lamp_blue,
  output logic             o_relay1_closed,
  output logic             o_relay2_closed,
  output logic             o_valve_open,
  output logic             o_alert,
  output logic             o_protection_ok_indication,
  output logic      [1:0]  o_display_sel,
  output logic      [3:0]  o_menu_item,
  output logic      [1:0]  o_cursor,
  output logic      [15:0] o_entry_digits,
  output logic             o_param_confirm,
  output logic      [15:0] o_param_value
);

  epc_db_if db ();

  epc_debounce #(
    .P_DB_CYCLES (P_DB_CYCLES)
  ) u_debounce (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_right  (i_btn_right),
    .i_up     (i_btn_up),
    .i_down   (i_btn_down),
    .i_enter  (i_btn_enter),
    .i_switch (i_ext_switch),
    .db       (db.src)
  );

  // one bcd digit stepped up or down with wrap
  function automatic logic [3:0] digit_step(input logic [3:0] d,
                                            input logic       up);
    logic [3:0] r;
    r = d;
    if (up) begin
      r = (d >= `EPC_DIGIT_MAX) ? 4'h0 : d + 4'h1;
    end else begin
      r = (d == 4'h0) ? `EPC_DIGIT_MAX : d - 4'h1;
    end
    return r;
  endfunction

  // step the digit under the cursor, leftmost digit is cursor 0
  function automatic logic [15:0] code_step(input logic [15:0] c,
                                            input logic [1:0]  cur,
                                            input logic        up);
    logic [15:0] r;
    r = c;
    case (cur)
      2'h0: begin
        r[`EPC_D0_LSB +: `EPC_DIGIT_W] =
          digit_step(c[`EPC_D0_LSB +: `EPC_DIGIT_W], up);
      end
      2'h1: begin
        r[`EPC_D1_LSB +: `EPC_DIGIT_W] =
          digit_step(c[`EPC_D1_LSB +: `EPC_DIGIT_W], up);
      end
      2'h2: begin
        r[`EPC_D2_LSB +: `EPC_DIGIT_W] =
          digit_step(c[`EPC_D2_LSB +: `EPC_DIGIT_W], up);
      end
      default: begin
        r[`EPC_D3_LSB +: `EPC_DIGIT_W] =
          digit_step(c[`EPC_D3_LSB +: `EPC_DIGIT_W], up);
      end
    endcase
    return r;
  endfunction

  // software override limit reached; zero limit never expires
  function automatic logic timed_out(input logic [15:0] max_s,
                                     input logic [16:0] cnt);
    logic r;
    r = 1'b0;
    if (max_s != `EPC_OVR_UNLIMITED) begin
      r = (cnt >= {max_s, 1'b0});
    end
    return r;
  endfunction

  epc_pkg::epc_panel_state_type s;
  epc_pkg::epc_panel_state_type next_s;

  logic        p_right;
  logic        p_up;
  logic        p_down;
  logic        p_enter;
  logic        sw_on;
  logic        sw_armed;
  logic        tick;
  logic        sw_ovr;
  logic        ovr_active;
  logic        ovr_expired;
  logic        normal_op;

  // debounced press pulses
  assign p_right = db.press[`EPC_IN_RIGHT];
  assign p_up    = db.press[`EPC_IN_UP];
  assign p_down  = db.press[`EPC_IN_DOWN];
  assign p_enter = db.press[`EPC_IN_ENTER];

  // switch polarity and arming
  assign sw_on = i_sw_positive ? db.level[`EPC_IN_SWITCH]
                               : ~db.level[`EPC_IN_SWITCH];
  assign normal_op = i_purge_done && !i_purging;
  assign sw_armed  = normal_op;

  // override timing in half-second steps
  assign tick      = (s.half_cnt >= P_HALF_CYCLES - 24'h000001);
  assign ovr_expired = timed_out(i_override_max_s, s.ovr_cnt);
  assign sw_ovr    = (s.mode == epc_pkg::EPC_M_OVERRIDE) ||
                     (s.mode == epc_pkg::EPC_M_OVR_CODE && s.deactivating);
  assign ovr_active = sw_ovr || s.key_ovr;

  // mode sequencing, code entry and lamp decode
  always_comb begin
    next_s = s;
    next_s.confirm = 1'b0;
    next_s.half_cnt = tick ? '0 : s.half_cnt + 24'h000001;
    if (tick) begin
      next_s.flash = ~s.flash;
    end

    // switch functions; none leaves all three low
    next_s.key_ovr = sw_armed && (i_sw_func == `EPC_SWF_OVERRIDE)
                     && sw_on;
    next_s.alert   = sw_armed && (i_sw_func == `EPC_SWF_ALERT)
                     && sw_on;
    next_s.cooling = sw_armed && (i_sw_func == `EPC_SWF_THERMO)
                     && sw_on;

    // override timer, held at its top so it never wraps
    if (!sw_ovr) begin
      next_s.ovr_cnt = '0;
    end else if (tick && s.ovr_cnt != '1) begin
      next_s.ovr_cnt = s.ovr_cnt + 17'h00001;
    end

    case (s.mode)
      // operation: override request, info display, menu entry
      epc_pkg::EPC_M_OP: begin
        if (p_up) begin
          next_s.mode = epc_pkg::EPC_M_OVR_CODE;
          next_s.digits = '0;
          next_s.cursor = '0;
          next_s.deactivating = 1'b0;
        end else if (p_down) begin
          next_s.disp_sel = (s.disp_sel == `EPC_DISP_PURGE_TIME)
                            ? `EPC_DISP_STATE
                            : s.disp_sel + 2'h1;
        end else if (p_enter) begin
          next_s.mode = epc_pkg::EPC_M_MENU_CODE;
          next_s.digits = '0;
          next_s.cursor = '0;
        end
      end

      // override: time limit or a new code entry to leave
      epc_pkg::EPC_M_OVERRIDE: begin
        if (ovr_expired) begin
          next_s.mode = epc_pkg::EPC_M_OP;
        end else if (p_up) begin
          next_s.mode = epc_pkg::EPC_M_OVR_CODE;
          next_s.digits = '0;
          next_s.cursor = '0;
          next_s.deactivating = 1'b1;
        end
      end

      // digit entry shared by both codes and parameter edit
      epc_pkg::EPC_M_OVR_CODE,
      epc_pkg::EPC_M_MENU_CODE,
      epc_pkg::EPC_M_EDIT: begin
        if (s.deactivating && s.mode == epc_pkg::EPC_M_OVR_CODE &&
            ovr_expired) begin
          next_s.mode = epc_pkg::EPC_M_OP;
          next_s.deactivating = 1'b0;
        end else if (p_right) begin
          next_s.cursor = s.cursor + 2'h1;
        end else if (p_up) begin
          next_s.digits = code_step(s.digits, s.cursor, 1'b1);
        end else if (p_down) begin
          next_s.digits = code_step(s.digits, s.cursor, 1'b0);
        end else if (p_enter) begin
          next_s.cursor = '0;
          if (s.mode == epc_pkg::EPC_M_OVR_CODE) begin
            if (s.digits == s.ovr_code) begin
              next_s.mode = s.deactivating ? epc_pkg::EPC_M_OP
                                           : epc_pkg::EPC_M_OVERRIDE;
            end else begin
              next_s.mode = s.deactivating ? epc_pkg::EPC_M_OVERRIDE
                                           : epc_pkg::EPC_M_OP;
            end
            next_s.deactivating = 1'b0;
          end else if (s.mode == epc_pkg::EPC_M_MENU_CODE) begin
            next_s.mode = (s.digits == s.master_code)
                          ? epc_pkg::EPC_M_MENU
                          : epc_pkg::EPC_M_OP;
          end else begin
            next_s.mode = epc_pkg::EPC_M_MENU;
            next_s.confirm = 1'b1;
            next_s.param_value = s.digits;
            if (s.menu_item == `EPC_ITEM_OVR_CODE) begin
              next_s.ovr_code = s.digits;
            end
            if (s.menu_item == `EPC_ITEM_MASTER) begin
              next_s.master_code = s.digits;
            end
          end
        end
      end

      // menu: walk items, open edit or leave on item zero
      epc_pkg::EPC_M_MENU: begin
        if (p_up) begin
          next_s.menu_item = s.menu_item + 4'h1;
        end else if (p_down) begin
          next_s.menu_item = s.menu_item - 4'h1;
        end else if (p_enter) begin
          if (s.menu_item == `EPC_ITEM_EXIT) begin
            next_s.mode = epc_pkg::EPC_M_OP;
          end else begin
            next_s.mode = epc_pkg::EPC_M_EDIT;
            next_s.digits = '0;
            next_s.cursor = '0;
          end
        end
      end

      // unknown code falls back to operation
      default: begin
        next_s.mode = epc_pkg::EPC_M_OP;
      end
    endcase

    // lamp colour by priority, yellow = red+green, purple = red+blue
    next_s.lamp_red = 1'b0;
    next_s.lamp_green = 1'b0;
    next_s.lamp_blue = 1'b0;
    next_s.relays_closed = 1'b0;
    if (ovr_active) begin
      next_s.lamp_red = 1'b1;
      next_s.lamp_blue = 1'b1;
      next_s.relays_closed = 1'b1;
    end else if (s.mode == epc_pkg::EPC_M_MENU ||
                 s.mode == epc_pkg::EPC_M_EDIT ||
                 s.mode == epc_pkg::EPC_M_MENU_CODE) begin
      next_s.lamp_blue = 1'b1;
    end else if (i_pressure_high) begin
      next_s.lamp_red = s.flash;
    end else if (s.alert || (normal_op && i_pressure_low)) begin
      next_s.lamp_red = 1'b1;
    end else if (i_purging) begin
      next_s.lamp_red = 1'b1;
      next_s.lamp_green = 1'b1;
    end else if (normal_op) begin
      next_s.lamp_green = s.cooling ? s.flash : 1'b1;
      next_s.relays_closed = 1'b1;
    end else begin
      next_s.lamp_red = 1'b1;
    end
    // protection ok while either override holds the relays
    next_s.prot_ok = sw_ovr && s.mode == epc_pkg::EPC_M_OVERRIDE ||
                     s.key_ovr || (sw_ovr && s.deactivating);
  end

  // single state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.mode <= epc_pkg::EPC_M_OP;
      // factory codes come back on every reset
      s.ovr_code <= `EPC_OVR_CODE_RESET;
      s.master_code <= `EPC_MASTER_RESET;
      s.disp_sel <= `EPC_DISP_STATE;
      s.menu_item <= `EPC_ITEM_EXIT;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign o_mode          = s.mode;
  assign o_lamp_red      = s.lamp_red;
  assign o_lamp_green    = s.lamp_green;
  assign o_lamp_blue     = s.lamp_blue;
  assign o_relay1_closed = s.relays_closed;
  assign o_relay2_closed = s.relays_closed;
  assign o_valve_open    = s.cooling;
  assign o_alert         = s.alert;
  assign o_protection_ok_indication = s.prot_ok;
  assign o_display_sel   = s.disp_sel;
  assign o_menu_item     = s.menu_item;
  assign o_cursor        = s.cursor;
  assign o_entry_digits  = s.digits;
  assign o_param_confirm = s.confirm;
  assign o_param_value   = s.param_value;

endmodule

// [epc_defines.svh]
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

// clock and timing
`define EPC_CLK_PERIOD_NS   40
`define EPC_DEBOUNCE_MS     20
`define EPC_FLASH_HALF_MS   500
`define EPC_NS_PER_MS       1000000
`define EPC_DEBOUNCE_CYCLES ((`EPC_DEBOUNCE_MS * `EPC_NS_PER_MS) / `EPC_CLK_PERIOD_NS)
`define EPC_HALF_SEC_CYCLES ((`EPC_FLASH_HALF_MS * `EPC_NS_PER_MS) / `EPC_CLK_PERIOD_NS)
`define EPC_DB_CNT_W        20
`define EPC_HALF_CNT_W      24
`define EPC_OVR_CNT_W       17

// debounced input positions
`define EPC_IN_N            5
`define EPC_IN_RIGHT        0
`define EPC_IN_UP           1
`define EPC_IN_DOWN         2
`define EPC_IN_ENTER        3
`define EPC_IN_SWITCH       4

// switch input function codes
`define EPC_SWF_NONE        2'h0
`define EPC_SWF_OVERRIDE    2'h1
`define EPC_SWF_ALERT       2'h2
`define EPC_SWF_THERMO      2'h3

// display selection codes
`define EPC_DISP_STATE      2'h0
`define EPC_DISP_PRESSURE   2'h1
`define EPC_DISP_PURGE_TIME 2'h2

// menu
`define EPC_ITEM_W          4
`define EPC_ITEM_EXIT       4'h0
`define EPC_ITEM_OVR_CODE   4'h1
`define EPC_ITEM_MASTER     4'h2

// code entry, four bcd digits
`define EPC_CODE_W          16
`define EPC_OVR_CODE_RESET  16'h0002
`define EPC_MASTER_RESET    16'h0001
`define EPC_DIGIT_MAX       4'h9
`define EPC_CURSOR_W        2
`define EPC_DIGIT_W         4
`define EPC_D0_LSB          12
`define EPC_D1_LSB          8
`define EPC_D2_LSB          4
`define EPC_D3_LSB          0

// override time limit of zero means no limit
`define EPC_OVR_UNLIMITED   16'h0000

`endif

// [epc_pkg.sv]
package epc_pkg;

  typedef enum logic [5:0] {
    EPC_M_OP        = 6'h01,
    EPC_M_OVR_CODE  = 6'h02,
    EPC_M_OVERRIDE  = 6'h04,
    EPC_M_MENU_CODE = 6'h08,
    EPC_M_MENU      = 6'h10,
    EPC_M_EDIT      = 6'h20
  } epc_mode_type;

  typedef struct packed {
    logic [4:0]        sync1;
    logic [4:0]        sync2;
    logic [4:0]        level;
    logic [4:0]        press;
    logic [4:0][19:0]  cnt;
  } epc_db_state_type;

  typedef struct packed {
    epc_mode_type mode;
    logic [1:0]   cursor;
    logic [15:0]  digits;
    logic [15:0]  ovr_code;
    logic [15:0]  master_code;
    logic [3:0]   menu_item;
    logic [1:0]   disp_sel;
    logic         deactivating;
    logic         key_ovr;
    logic         alert;
    logic         cooling;
    logic [23:0]  half_cnt;
    logic         flash;
    logic [16:0]  ovr_cnt;
    logic         confirm;
    logic [15:0]  param_value;
    logic         lamp_red;
    logic         lamp_green;
    logic         lamp_blue;
    logic         relays_closed;
    logic         prot_ok;
  } epc_panel_state_type;

endpackage

// [epc_db_if.sv]
`timescale 1ns/1ps
interface epc_db_if;
  logic [4:0] level;
  logic [4:0] press;
  modport src (output level, output press);
  modport dst (input level, input press);
endinterface

// [epc_debounce.sv]
`timescale 1ns/1ps
`include "epc_defines.svh"
module epc_debounce #(
  parameter logic [19:0] P_DB_CYCLES = 20'(`EPC_DEBOUNCE_CYCLES)
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  input  wire logic  i_right,
  input  wire logic  i_up,
  input  wire logic  i_down,
  input  wire logic  i_enter,
  input  wire logic  i_switch,
  epc_db_if.src      db
);

  epc_pkg::epc_db_state_type s;
  epc_pkg::epc_db_state_type next_s;

  // two-stage sync, then a level must hold for the debounce time
  always_comb begin
    next_s = s;
    next_s.sync1 = {i_switch, i_enter, i_down, i_up, i_right};
    next_s.sync2 = s.sync1;
    next_s.press = '0;
    for (int i = 0; i < `EPC_IN_N; i++) begin
      if (s.sync2[i] == s.level[i]) begin
        next_s.cnt[i] = '0;
      end else if (s.cnt[i] >= P_DB_CYCLES - 20'h00001) begin
        next_s.cnt[i] = '0;
        next_s.level[i] = s.sync2[i];
        next_s.press[i] = s.sync2[i];
      end else begin
        next_s.cnt[i] = s.cnt[i] + 20'h00001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign db.level = s.level;
  assign db.press = s.press;

endmodule

// [epc_panel_sva.sv]
`timescale 1ns/1ps
module epc_panel_sva (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_sw_func,
  input  wire logic       i_purging,
  input  wire logic       i_purge_done,
  input  wire logic       i_pressure_high,
  input  wire logic [5:0] o_mode,
  input  wire logic       o_lamp_red,
  input  wire logic       o_lamp_green,
  input  wire logic       o_lamp_blue,
  input  wire logic       o_relay1_closed,
  input  wire logic       o_relay2_closed,
  input  wire logic       o_valve_open,
  input  wire logic       o_alert,
  input  wire logic       o_protection_ok_indication,
  input  wire logic [1:0] o_cursor,
  input  wire logic       o_param_confirm
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // lamp, relay and mode relations
  chk_relay_pair: assert property (
    o_relay1_closed == o_relay2_closed) else $error("relays differ");
  chk_menu_blue: assert property (
    o_mode == 6'h10 && $past(o_mode) == 6'h10 |-> o_lamp_blue &&
    !o_lamp_red && !o_relay1_closed) else $error("menu lamp wrong");
  chk_ovr_purple: assert property (
    o_mode == 6'h04 && $past(o_mode) == 6'h04 |-> o_lamp_red &&
    o_lamp_blue && o_relay1_closed && o_protection_ok_indication)
    else $error("override lamp wrong");
  chk_high_open: assert property (
    i_pressure_high && $past(i_pressure_high) && o_mode == 6'h01 &&
    $past(o_mode) == 6'h01 && !o_protection_ok_indication |->
    !o_relay1_closed && !o_lamp_green) else $error("high not open");
  chk_confirm_pulse: assert property (
    o_param_confirm |=> !o_param_confirm) else $error("confirm long");
  chk_right_idle: assert property (
    o_mode == 6'h01 && $past(o_mode) == 6'h01 |-> $stable(o_cursor))
    else $error("cursor moved in op");
  chk_alert_cause: assert property (
    $rose(o_alert) |-> $past(i_purge_done && !i_purging &&
    i_sw_func == 2'h2)) else $error("alert without cause");
  chk_valve_cause: assert property (
    o_valve_open |-> $past(i_sw_func) == 2'h3)
    else $error("valve without thermostat");
  chk_menu_gate: assert property (
    o_mode == 6'h10 && $past(o_mode) != 6'h10 |->
    $past(o_mode) == 6'h08 || $past(o_mode) == 6'h20)
    else $error("menu without code");
  chk_ovr_gate: assert property (
    o_mode == 6'h04 && $past(o_mode) != 6'h04 |->
    $past(o_mode) == 6'h02) else $error("override without code");
endmodule
bind epc_panel epc_panel_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_sw_func(i_sw_func), .i_purging(i_purging),
  .i_purge_done(i_purge_done), .i_pressure_high(i_pressure_high),
  .o_mode(o_mode), .o_lamp_red(o_lamp_red),
  .o_lamp_green(o_lamp_green), .o_lamp_blue(o_lamp_blue),
  .o_relay1_closed(o_relay1_closed), .o_relay2_closed(o_relay2_closed),
  .o_valve_open(o_valve_open), .o_alert(o_alert),
  .o_protection_ok_indication(o_protection_ok_indication),
  .o_cursor(o_cursor), .o_param_confirm(o_param_confirm));

// [epc_operator.sv]
`timescale 1ns/1ps
module epc_operator (
  input  wire logic       i_clk,
  output logic      [3:0] o_btn,
  output logic            o_contact
);
  initial begin
    o_btn = 4'h0;
    o_contact = 1'b0;
  end
  // press with a short bounce first, hold, release
  task automatic press(input int b);
    @(negedge i_clk);
    o_btn[b] = 1'b1;
    repeat (2) @(negedge i_clk);
    o_btn[b] = 1'b0;
    @(negedge i_clk);
    o_btn[b] = 1'b1;
    repeat (12) @(negedge i_clk);
    o_btn[b] = 1'b0;
    repeat (12) @(negedge i_clk);
  endtask
  // passive contact level
  task automatic set_contact(input logic v);
    @(negedge i_clk);
    o_contact = v;
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int BR = 0;
  localparam int BU = 1;
  localparam int BD = 2;
  localparam int BE = 3;
  logic        clk, rst, sw_pos, purging, done, p_low, p_high;
  logic        red, green, blue, rel1, rel2, valve, alert, pok, conf;
  logic        contact, prev;
  logic [1:0]  func, disp, cur;
  logic [3:0]  btn, item;
  logic [5:0]  mode;
  logic [15:0] max_s, digits, pval;
  int          mismatches, comparisons, confs, n;
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  epc_operator u_op (.i_clk(clk), .o_btn(btn), .o_contact(contact));
  epc_panel #(.P_DB_CYCLES(20'h4), .P_HALF_CYCLES(24'h8)) u_dut (
    .i_clk(clk), .i_rst(rst), .i_btn_right(btn[BR]), .i_btn_up(btn[BU]),
    .i_btn_down(btn[BD]), .i_btn_enter(btn[BE]), .i_ext_switch(contact),
    .i_sw_func(func), .i_sw_positive(sw_pos), .i_override_max_s(max_s),
    .i_purging(purging), .i_purge_done(done), .i_pressure_low(p_low),
    .i_pressure_high(p_high), .o_mode(mode), .o_lamp_red(red),
    .o_lamp_green(green), .o_lamp_blue(blue), .o_relay1_closed(rel1),
    .o_relay2_closed(rel2), .o_valve_open(valve), .o_alert(alert),
    .o_protection_ok_indication(pok), .o_display_sel(disp),
    .o_menu_item(item), .o_cursor(cur), .o_entry_digits(digits),
    .o_param_confirm(conf), .o_param_value(pval));
  // count confirm pulses
  always @(negedge clk) begin
    if (conf === 1'b1)
      confs++;
  end
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // lamps as red, green, blue, relay
  task automatic lamps(input logic [3:0] e);
    check("lamps", {12'h000, e}, {12'h000, red, green, blue, rel1});
    check("relay2", {15'h0, e[0]}, {15'h0, rel2});
  endtask
  // four bcd digits left to right, then enter
  task automatic code(input logic [15:0] c);
    for (int i = 0; i < 4; i++) begin
      repeat (c[15-4*i -: 4]) u_op.press(BU);
      u_op.press(BR);
    end
    u_op.press(BE);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    finish_test;
  end
  initial begin
    {rst, purging} = 2'h3;
    {func, sw_pos, done, p_low, p_high} = 6'h0c;
    max_s = 16'h0000;
    repeat (16) @(negedge clk);
    lamps(4'h0);
    rst = 1'b0;
    settle();
    lamps(4'hc);
    {purging, done} = 2'h1;
    settle();
    lamps(4'h5);
    p_low = 1'b1;
    settle();
    lamps(4'h8);
    p_low = 1'b0;
    for (int i = 1; i < 4; i++) begin
      u_op.press(BD);
      check("display", 16'(i % 3), disp);
    end
    u_op.press(BR);
    check("cursor", 16'h0000, cur);
    u_op.press(BU);
    check("mode", 16'h0002, mode);
    u_op.press(BR);
    check("cursor", 16'h0001, cur);
    u_op.press(BU);
    check("digits", 16'h0100, digits);
    code(16'h0005);
    check("mode", 16'h0001, mode);
    u_op.press(BU);
    code(16'h0002);
    check("mode", 16'h0004, mode);
    lamps(4'hb);
    check("prot_ok", 16'h0001, pok);
    u_op.press(BU);
    code(16'h0002);
    check("mode", 16'h0001, mode);
    max_s = 16'h0002;
    {purging, done} = 2'h2;
    u_op.press(BU);
    code(16'h0002);
    check("mode", 16'h0004, mode);
    repeat (40) @(negedge clk);
    check("mode", 16'h0001, mode);
    lamps(4'hc);
    max_s = 16'h0000;
    {purging, done} = 2'h1;
    u_op.press(BE);
    check("mode", 16'h0008, mode);
    code(16'h0001);
    check("mode", 16'h0010, mode);
    lamps(4'h2);
    u_op.press(BU);
    check("item", 16'h0001, item);
    u_op.press(BU);
    u_op.press(BD);
    check("item", 16'h0001, item);
    u_op.press(BE);
    check("mode", 16'h0020, mode);
    code(16'h0003);
    check("confirms", 16'h0001, 16'(confs));
    check("value", 16'h0003, pval);
    u_op.press(BD);
    u_op.press(BE);
    check("mode", 16'h0001, mode);
    u_op.press(BU);
    code(16'h0002);
    check("mode", 16'h0001, mode);
    u_op.press(BU);
    code(16'h0003);
    check("mode", 16'h0004, mode);
    u_op.press(BU);
    code(16'h0003);
    for (int f = 0; f < 4; f++) begin
      func = 2'(f);
      u_op.set_contact(1'b1);
      repeat (12) @(negedge clk);
      check("alert", 16'(f == 2), alert);
      check("valve", 16'(f == 3), valve);
      check("relay", 16'(f != 2), rel1);
      check("blue", 16'(f == 1), blue);
      u_op.set_contact(1'b0);
      repeat (12) @(negedge clk);
    end
    check("blue", 16'h0000, blue);
    {func, sw_pos} = 3'h4;
    repeat (12) @(negedge clk);
    check("alert", 16'h0001, alert);
    done = 1'b0;
    settle();
    check("alert", 16'h0000, alert);
    {func, sw_pos, done} = 4'h3;
    p_high = 1'b1;
    for (int k = 0; k < 2; k++) begin
      prev = red;
      n = 0;
      while (red === prev && n < 40) begin
        @(negedge clk);
        n++;
      end
    end
    check("flash", 16'h0008, 16'(n));
    check("relay", 16'h0000, rel1);
    // mid-run reset brings back the factory codes
    p_high = 1'b0;
    rst = 1'b1;
    settle();
    lamps(4'h0);
    rst = 1'b0;
    settle();
    lamps(4'h5);
    u_op.press(BU);
    code(16'h0002);
    check("mode", 16'h0004, mode);
    u_op.press(BU);
    code(16'h0002);
    check("mode", 16'h0001, mode);
    // store a new master code through menu item two
    u_op.press(BE);
    code(16'h0001);
    u_op.press(BU);
    u_op.press(BU);
    u_op.press(BE);
    code(16'h0007);
    check("confirms", 16'h0002, 16'(confs));
    check("value", 16'h0007, pval);
    u_op.press(BD);
    u_op.press(BD);
    u_op.press(BE);
    u_op.press(BE);
    code(16'h0001);
    check("mode", 16'h0001, mode);
    u_op.press(BE);
    code(16'h0007);
    check("mode", 16'h0010, mode);
    finish_test;
  end
endmodule
